/* File: hdl/crma_pkg.sv */
// Purpose: constants and types shared by the configuration message endpoint
// Assumes: tokens arrive one byte per cycle with a control flag beside them
package crma_pkg;
   localparam logic [7:0] CT_WRITE = 8'hC0; // 192
   localparam logic [7:0] CT_READ = 8'hC1; // 193
   localparam logic [7:0] CT_END = 8'h01;
   localparam logic [7:0] CT_ACK = 8'h03;
   localparam logic [7:0] CT_NACK = 8'h04;
   localparam logic [7:0] NO_REPLY_LO = 8'hFF;
   localparam logic [15:0] TILE_DEST_LO = 16'hC20C;
   localparam logic [15:0] NODE_DEST_LO = 16'hC30C;
   localparam logic [7:0] PS_RES_TYPE = 8'h0B;
   localparam int ID_BYTES = 3;
   localparam int REG_BYTES = 2;
   localparam int DATA_BYTES = 4;
   localparam int NUM_REGS = 16;
   localparam logic [31:0] REG_RESET = 32'h0000_0000;
   typedef enum logic [3:0] {
      CRMA_IDLE, CRMA_ID, CRMA_REG, CRMA_DATA, CRMA_END, CRMA_FLUSH,
      CRMA_R_HEAD, CRMA_R_DATA, CRMA_R_END
   } crma_state_t;
   // processor-status resource id
   function automatic logic [31:0] crma_ps_resource(input logic [15:0] regnum);
      crma_ps_resource = {8'h00, regnum, PS_RES_TYPE};
   endfunction
endpackage

/* File: hdl/crma_regmem.sv */
// Purpose: small register store for the configuration endpoint
// Assumes: one access per cycle
// Notes: read data registered
`timescale 1ns/1ps
`default_nettype none
module crma_regmem
   import crma_pkg::*;
#(
   parameter int DEPTH = NUM_REGS,
   parameter int AW = $clog2(NUM_REGS)
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // access
   input wire logic we,
   input wire logic [AW-1:0] addr,
   input wire logic [31:0] wdata,
   output logic [31:0] rdata
);
   logic [31:0] mem_ff [DEPTH];
   logic [31:0] rdata_ff;
   // storage reset to a known value so reads are defined
   always_ff @(posedge clk) begin
      rdata_ff <= mem_ff[addr];
      for (int i = 0; i < DEPTH; i++) begin
         if (rst) begin
            mem_ff[i] <= REG_RESET;
         end else if (we && addr == AW'(i)) begin
            mem_ff[i] <= wdata;
         end
      end
   end
   assign rdata = rdata_ff;
endmodule // crma_regmem
`default_nettype wire

/* File: hdl/crma_endpoint.sv */
// Purpose: decode token-framed config messages and send replies
// Assumes: byte stream with ctl flag; in_valid/out_ready handshakes
// Notes: one message in flight; new requests wait while a reply goes out
`timescale 1ns/1ps
`default_nettype none
module crma_endpoint
   import crma_pkg::*;
#(
   parameter int AW = $clog2(NUM_REGS)
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // request stream
   input wire logic in_valid,
   input wire logic in_ctl,
   input wire logic [7:0] in_data,
   output logic in_ready,
   // reply stream
   output logic out_valid,
   output logic out_ctl,
   output logic [7:0] out_data,
   output logic [23:0] out_dest,
   input wire logic out_ready
);
   crma_state_t st_ff, nxt_st;
   logic [23:0] id_ff, nxt_id;
   logic [15:0] reg_ff, nxt_reg;
   logic [31:0] wd_ff, nxt_wd;
   logic [1:0] cnt_ff, nxt_cnt;
   logic wr_ff, nxt_wr;
   logic ok_ff, nxt_ok;
   logic we;
   logic [31:0] rdata;
   logic take, send;

   assign in_ready = (st_ff inside {CRMA_IDLE, CRMA_ID, CRMA_REG, CRMA_DATA,
                                    CRMA_END, CRMA_FLUSH});
   assign take = in_valid && in_ready;
   assign send = out_valid && out_ready;
   assign out_dest = id_ff;
   assign out_valid = st_ff inside {CRMA_R_HEAD, CRMA_R_DATA, CRMA_R_END};

   // registers implemented: low register numbers only
   function automatic logic reg_ok(input logic [15:0] r);
      reg_ok = (r < 16'(NUM_REGS));
   endfunction

   // a write whose reply id low byte is all ones asks for no answer, good or bad
   function automatic logic reply_off(input logic w, input logic [23:0] i);
      reply_off = w && i[7:0] == NO_REPLY_LO;
   endfunction

   assign we = take && st_ff == CRMA_END && in_ctl && in_data == CT_END && wr_ff
               && reg_ok(reg_ff);

   crma_regmem #(.DEPTH(NUM_REGS), .AW(AW)) u_mem (
      .clk(clk),
      .rst(rst),
      .we(we),
      .addr(reg_ff[AW-1:0]),
      .wdata(wd_ff),
      .rdata(rdata)
   );

   // reply byte selection, data most significant byte first
   always_comb begin
      out_ctl = 1'b1;
      out_data = CT_END;
      unique case (st_ff)
         CRMA_R_HEAD: out_data = ok_ff ? CT_ACK : CT_NACK;
         CRMA_R_DATA: begin
            out_ctl = 1'b0;
            out_data = rdata[8*(3-cnt_ff) +: 8];
         end
         default: out_data = CT_END;
      endcase
   end

   // message parser and reply sequencer
   always_comb begin
      nxt_st = st_ff;
      nxt_id = id_ff;
      nxt_reg = reg_ff;
      nxt_wd = wd_ff;
      nxt_cnt = cnt_ff;
      nxt_wr = wr_ff;
      nxt_ok = ok_ff;
      unique case (st_ff)
         CRMA_IDLE: if (take && in_ctl) begin
            // stray tokens outside a header are dropped silently
            if (in_data == CT_WRITE || in_data == CT_READ) begin
               nxt_wr = (in_data == CT_WRITE);
               nxt_cnt = '0;
               nxt_st = CRMA_ID;
            end
         end
         CRMA_ID: if (take) begin
            nxt_id = {id_ff[15:0], in_data};
            nxt_cnt = cnt_ff + 2'd1;
            if (in_ctl) begin
               nxt_id = '0;
               nxt_ok = 1'b0;
               nxt_st = CRMA_FLUSH;
            end else if (cnt_ff == 2'(ID_BYTES - 1)) begin
               nxt_cnt = '0;
               nxt_st = CRMA_REG;
            end
         end
         CRMA_REG: if (take) begin
            nxt_reg = {reg_ff[7:0], in_data};
            nxt_cnt = cnt_ff + 2'd1;
            if (in_ctl) begin
               nxt_ok = 1'b0;
               nxt_st = CRMA_FLUSH;
            end else if (cnt_ff == 2'(REG_BYTES - 1)) begin
               nxt_cnt = '0;
               nxt_st = wr_ff ? CRMA_DATA : CRMA_END;
            end
         end
         CRMA_DATA: if (take) begin
            nxt_wd = {wd_ff[23:0], in_data};
            nxt_cnt = cnt_ff + 2'd1;
            if (in_ctl) begin
               nxt_ok = 1'b0;
               nxt_st = CRMA_FLUSH;
            end else if (cnt_ff == 2'(DATA_BYTES - 1)) begin
               nxt_cnt = '0;
               nxt_st = CRMA_END;
            end
         end
         CRMA_END: if (take) begin
            nxt_ok = in_ctl && in_data == CT_END && reg_ok(reg_ff);
            nxt_cnt = '0;
            if (in_ctl && in_data == CT_END) begin
               nxt_st = reply_off(wr_ff, id_ff) ? CRMA_IDLE : CRMA_R_HEAD;
            end else if (in_ctl) begin
               // a wrong control token fails at once, still silent when suppressed
               nxt_st = reply_off(wr_ff, id_ff) ? CRMA_IDLE : CRMA_R_HEAD;
            end else begin
               nxt_st = CRMA_FLUSH;
            end
         end
         CRMA_FLUSH: if (take && in_ctl && in_data == CT_END) begin
            // malformed message: consume to its end token, then fail
            nxt_st = reply_off(wr_ff, id_ff) ? CRMA_IDLE : CRMA_R_HEAD;
         end
         CRMA_R_HEAD: if (send) begin
            nxt_st = (ok_ff && !wr_ff) ? CRMA_R_DATA : CRMA_R_END;
         end
         CRMA_R_DATA: if (send) begin
            nxt_cnt = cnt_ff + 2'd1;
            if (cnt_ff == 2'(DATA_BYTES - 1)) begin
               nxt_st = CRMA_R_END;
            end
         end
         CRMA_R_END: if (send) begin
            nxt_st = CRMA_IDLE;
         end
         default: nxt_st = CRMA_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_ff <= CRMA_IDLE;
         id_ff <= '0;
         reg_ff <= '0;
         wd_ff <= '0;
         cnt_ff <= '0;
         wr_ff <= 1'b0;
         ok_ff <= 1'b0;
      end else begin
         st_ff <= nxt_st;
         id_ff <= nxt_id;
         reg_ff <= nxt_reg;
         wd_ff <= nxt_wd;
         cnt_ff <= nxt_cnt;
         wr_ff <= nxt_wr;
         ok_ff <= nxt_ok;
      end
   end

   // checks
   reply_head_a: assert property (@(posedge clk) disable iff (rst)
      st_ff == CRMA_R_HEAD |-> out_ctl && (out_data == CT_ACK || out_data == CT_NACK))
      else $error("bad reply head");
   reply_tail_a: assert property (@(posedge clk) disable iff (rst)
      st_ff == CRMA_R_END |-> out_ctl && out_data == CT_END)
      else $error("bad reply tail");
   no_reply_a: assert property (@(posedge clk) disable iff (rst)
      (st_ff == CRMA_END && take && in_ctl && in_data == CT_END && wr_ff
       && id_ff[7:0] == NO_REPLY_LO) |=> st_ff == CRMA_IDLE && !out_valid)
      else $error("suppressed reply was sent");
   fail_reg_a: assert property (@(posedge clk) disable iff (rst)
      st_ff == CRMA_R_HEAD && !reg_ok(reg_ff) |-> out_data == CT_NACK)
      else $error("unknown register acked");
   read_len_a: assert property (@(posedge clk) disable iff (rst)
      (st_ff == CRMA_R_HEAD && send && ok_ff && !wr_ff) |=> st_ff == CRMA_R_DATA)
      else $error("read data missing");
   msb_first_a: assert property (@(posedge clk) disable iff (rst)
      (st_ff == CRMA_R_DATA && cnt_ff == 2'd0)
      |-> out_data == u_mem.mem_ff[reg_ff[AW-1:0]][31:24])
      else $error("data not msb first");
   write_go_a: assert property (@(posedge clk) disable iff (rst)
      take && st_ff == CRMA_IDLE && in_ctl && in_data == CT_WRITE |=> st_ff == CRMA_ID && wr_ff)
      else $error("write header missed");
   read_go_a: assert property (@(posedge clk) disable iff (rst)
      take && st_ff == CRMA_IDLE && in_ctl && in_data == CT_READ |=> st_ff == CRMA_ID && !wr_ff)
      else $error("read header missed");
   dest_a: assert property (@(posedge clk) disable iff (rst)
      out_valid |=> !out_valid || $stable(out_dest))
      else $error("reply destination wrong");
   ack_ok_a: assert property (@(posedge clk) disable iff (rst)
      st_ff == CRMA_R_HEAD && ok_ff |-> out_ctl && out_data == CT_ACK)
      else $error("good access not acked");
   hold_byte_a: assert property (@(posedge clk) disable iff (rst)
      out_valid && !out_ready |=> out_valid && $stable(out_data) && $stable(out_ctl))
      else $error("reply byte changed while stalled");
   store_write_a: assert property (@(posedge clk) disable iff (rst)
      we |=> u_mem.mem_ff[reg_ff[AW-1:0]] == wd_ff)
      else $error("write data not stored");
   end_data_a: assert property (@(posedge clk) disable iff (rst)
      take && st_ff == CRMA_END && !in_ctl |=> st_ff == CRMA_FLUSH && !ok_ff)
      else $error("data byte in end slot not failed");
   fail_quiet_a: assert property (@(posedge clk) disable iff (rst)
      take && st_ff == CRMA_END && in_ctl && reply_off(wr_ff, id_ff) |=> st_ff == CRMA_IDLE)
      else $error("suppressed write replied");
endmodule // crma_endpoint
`default_nettype wire

/* File: tb/crma_requester.sv */
// Purpose: remote channel-end requester facing the configuration endpoint
// Assumes: bench calls put/idle just after a rising edge
// Notes: reply sink stalls at random while stall_en is high
`timescale 1ns/1ps
`default_nettype none
module crma_requester
   import crma_pkg::*;
(
   // clock
   input wire logic clk,
   // request stream
   output logic in_valid,
   output logic in_ctl,
   output logic [7:0] in_data,
   input wire logic in_ready,
   // reply stream
   input wire logic out_valid,
   input wire logic out_ctl,
   input wire logic [7:0] out_data,
   input wire logic [23:0] out_dest,
   output logic out_ready,
   // behaviour
   input wire logic stall_en
);
   // destination the requester would program for each endpoint kind
   localparam logic [31:0] TILE_DEST = {16'h0001, TILE_DEST_LO};
   localparam logic [31:0] NODE_DEST = {16'h0002, NODE_DEST_LO};
   logic [32:0] rx_q [$];
   logic rdy_seen;
   logic stuck;
   initial begin
      in_valid = 1'b0;
      in_ctl = 1'b0;
      in_data = 8'h00;
      out_ready = 1'b1;
      rdy_seen = 1'b0;
      stuck = 1'b0;
   end
   // ready is sampled mid-cycle so the edge never races the state update
   always @(negedge clk) begin
      rdy_seen = in_ready;
   end
   // one byte offered and held until taken
   task automatic put(input logic c, input logic [7:0] d);
      int n = 0;
      in_valid <= 1'b1;
      in_ctl <= c;
      in_data <= d;
      do begin
         @(posedge clk);
         n++;
      end while (!rdy_seen && n < 200);
      if (!rdy_seen) stuck = 1'b1; // byte never taken: bench ends the run
   endtask
   // released data line shows the inverse, never a stale byte
   task automatic idle();
      in_valid <= 1'b0;
      in_ctl <= 1'b0;
      in_data <= ~in_data;
   endtask
   // reply bytes kept with the destination they were sent to
   always @(posedge clk) begin
      if (out_valid && out_ready) rx_q.push_back({out_dest, out_ctl, out_data});
      out_ready <= stall_en ? 1'(($urandom % 4) != 0) : 1'b1;
   end
endmodule // crma_requester
`default_nettype wire

/* File: tb/config_register_message_access_tb.sv */
// Purpose: self-checking bench for the configuration message endpoint
// Assumes: one message in flight, replies collected by the requester model
// Notes: random accesses against a reference store plus corner cases
`timescale 1ns/1ps
`default_nettype none
module config_register_message_access_tb
   import crma_pkg::*;
;
   logic clk, rst, stall_en, in_valid, in_ctl, in_ready, out_valid, out_ctl, out_ready;
   logic [7:0] in_data, out_data;
   logic [23:0] out_dest, id;
   logic [15:0] rn;
   logic [31:0] d, seed_word;
   logic wr, ok;
   logic [31:0] exp_mem [NUM_REGS];
   int error_cnt = 0;
   int checks_done = 0;
   crma_endpoint DUT (.clk(clk), .rst(rst), .in_valid(in_valid), .in_ctl(in_ctl),
      .in_data(in_data), .in_ready(in_ready), .out_valid(out_valid), .out_ctl(out_ctl),
      .out_data(out_data), .out_dest(out_dest), .out_ready(out_ready));
   crma_requester m (.clk(clk), .in_valid(in_valid), .in_ctl(in_ctl), .in_data(in_data),
      .in_ready(in_ready), .out_valid(out_valid), .out_ctl(out_ctl), .out_data(out_data),
      .out_dest(out_dest), .out_ready(out_ready), .stall_en(stall_en));
   // 250 MHz clock
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic chk(input logic [32:0] got, input logic [32:0] exp);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // resource identifier compare
   task automatic chk_res(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // status resource id from the register number
   function automatic logic [31:0] exp_res(input int r);
      exp_res = (32'(r) << 8) | 32'h0000_000B;
   endfunction
   task automatic tally_and_finish();
      $display("checks_done=%0d error_cnt=%0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // whole message, fields most significant byte first
   task automatic send(input logic w, input logic [23:0] i, input logic [15:0] r,
                       input logic [31:0] v, input logic stray);
      @(posedge clk);
      m.put(1'b1, w ? CT_WRITE : CT_READ);
      for (int k = 2; k >= 0; k--) m.put(1'b0, i[k*8+:8]);
      for (int k = 1; k >= 0; k--) m.put(1'b0, r[k*8+:8]);
      if (w) for (int k = 3; k >= 0; k--) m.put(1'b0, v[k*8+:8]);
      if (stray) m.put(1'b0, 8'h5A); // data byte where the end token belongs
      m.put(1'b1, CT_END);
      m.idle();
      if (m.stuck) begin
         error_cnt++;
         tally_and_finish();
      end
   endtask
   // expected reply built from the token rules, compared byte by byte
   task automatic expect_reply(input logic good, input logic rd, input logic [23:0] i,
                               input logic [31:0] v);
      int n = 0;
      logic [32:0] e [$];
      e.push_back({i, 1'b1, good ? CT_ACK : CT_NACK});
      if (good && rd) for (int k = 3; k >= 0; k--) e.push_back({i, 1'b0, v[k*8+:8]});
      e.push_back({i, 1'b1, CT_END});
      while (m.rx_q.size() < e.size() && n < 400) begin
         n++;
         @(posedge clk);
      end
      if (m.rx_q.size() < e.size()) begin
         error_cnt++;
         tally_and_finish();
      end
      foreach (e[k]) chk(m.rx_q[k], e[k]);
      m.rx_q.delete();
   endtask
   initial begin
      rst = 1'b1;
      stall_en = 1'b0;
      foreach (exp_mem[k]) exp_mem[k] = REG_RESET;
      seed_word = $urandom(98765);
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      // reset contents and status resource mapping
      for (int r = 0; r < NUM_REGS; r++) begin
         send(1'b0, 24'h000102, 16'(r), 32'h0, 1'b0);
         expect_reply(1'b1, 1'b1, 24'h000102, REG_RESET);
         chk_res(crma_ps_resource(16'(r)), exp_res(r));
      end
      // random traffic with a stalling sink; numbers above the store must fail
      stall_en <= 1'b1;
      repeat (60) begin
         wr = 1'($urandom % 2);
         id = 24'($urandom);
         if (id[7:0] == 8'hFF) id[7:0] = 8'h00;
         rn = 16'($urandom % (NUM_REGS + 2));
         d = $urandom;
         ok = rn < NUM_REGS;
         send(wr, id, rn, d, 1'b0);
         if (wr && ok) exp_mem[rn[3:0]] = d;
         expect_reply(ok, !wr, id, ok ? exp_mem[rn[3:0]] : 32'h0);
      end
      // suppressed replies, failing and good: next reply must be the read
      send(1'b1, 24'h0000FF, 16'h0100, 32'h1111_2222, 1'b0);
      send(1'b1, 24'hABCDFF, 16'h0005, 32'hCAFE_0001, 1'b0);
      exp_mem[5] = 32'hCAFE_0001;
      send(1'b0, 24'h123456, 16'h0005, 32'h0, 1'b0);
      expect_reply(1'b1, 1'b1, 24'h123456, exp_mem[5]);
      // malformed frames and top register number fail; store untouched
      send(1'b0, 24'h00A0B0, 16'h0003, 32'h0, 1'b1);
      expect_reply(1'b0, 1'b0, 24'h00A0B0, 32'h0);
      send(1'b1, 24'h00A0B1, 16'hFFFF, 32'h1, 1'b0);
      expect_reply(1'b0, 1'b0, 24'h00A0B1, 32'h0);
      send(1'b1, 24'h00A0B2, 16'h0007, 32'h1234_5678, 1'b1);
      expect_reply(1'b0, 1'b0, 24'h00A0B2, 32'h0);
      send(1'b0, 24'h00A0B3, 16'h0007, 32'h0, 1'b0);
      expect_reply(1'b1, 1'b1, 24'h00A0B3, exp_mem[7]);
      // destination low patterns the requester programs for each endpoint kind
      chk_res(32'(m.TILE_DEST[15:0]), 32'h0000_C20C);
      chk_res(32'(m.NODE_DEST[15:0]), 32'h0000_C30C);
      tally_and_finish();
   end
endmodule // config_register_message_access_tb
`default_nettype wire
